/* logic/kplw_pkg.sv */
// Package of constants and types for the keypad level wake-up block
package kplw_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] KPLW_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] KPLW_ADDR_STATUS  = 8'h01;
  localparam logic [7:0] KPLW_ADDR_IEN2    = 8'h02;
  localparam logic [7:0] KPLW_ADDR_IRQ_ST  = 8'h03;
  localparam logic [7:0] KPLW_ADDR_IRQ_MSK = 8'h04;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int KPLW_CTL_LEVEL_BIT  = 0;
  localparam int KPLW_CTL_MASK_BIT   = 1;
  localparam int KPLW_STA_FLAG_BIT   = 0;
  localparam int KPLW_STA_WAKE_BIT   = 1;
  localparam int KPLW_IEN_KEY_BIT    = 0;
  localparam int KPLW_EVT_DETECT_BIT = 0;
  localparam int KPLW_EVT_WAKE_BIT   = 1;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] KPLW_RST_CONTROL = 8'h00;
  localparam logic [7:0] KPLW_RST_STATUS  = 8'h00;
  localparam logic [7:0] KPLW_RST_IEN2    = 8'h00;
  localparam logic [1:0] KPLW_RST_EVT     = 2'h0;
  localparam logic [2:0] KPLW_RST_SYNC    = 3'h0;
  localparam int         KPLW_SYNC_STAGES = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } kplw_bus_t;

  typedef struct packed {
    logic key_level_select;
    logic key_irq_mask;
    logic key_wake_enable;
    logic key_irq_enable;
  } kplw_cfg_t;

endpackage

/* logic/kplw_top.sv */
// Keypad level detector with flag, interrupt and wake-up request
// ****************************************
// ****************************************
`timescale 1ns/100ps

module kplw_top
  import kplw_pkg::*;
#(
  // Synchroniser depth
  parameter int SYNC_STAGES = KPLW_SYNC_STAGES
)
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Keypad and core
  input  wire logic       KEYPAD_INPUT_LINE,
  output logic            KEY_IRQ,
  output logic            WAKE_REQ,
  output logic            IRQ
);

  // ****************************************
  // Parameter checks
  // ****************************************
  // Capture stage plus two agreeing stages
  if (SYNC_STAGES < 3) begin : g_bad_sync
    $error("kplw_top: SYNC_STAGES below three");
  end

  // ****************************************
  // Synchroniser
  // ****************************************
  logic [SYNC_STAGES-1:0] sync;
  logic [SYNC_STAGES-1:0] next_sync;
  logic                   key_sync;
  logic                   next_key_sync;

  always_comb begin
    next_sync = {sync[SYNC_STAGES-2:0], KEYPAD_INPUT_LINE};
    next_key_sync = key_sync;
    if (sync[SYNC_STAGES-2] == sync[SYNC_STAGES-1]) begin
      next_key_sync = sync[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync     <= SYNC_STAGES'(KPLW_RST_SYNC);
      key_sync <= 1'b0;
    end else begin
      sync     <= next_sync;
      key_sync <= next_key_sync;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  kplw_bus_t  bus;
  kplw_cfg_t  cfg;
  logic [7:0] control;
  logic [7:0] status;
  logic [7:0] ien2;
  logic [1:0] irq_st;
  logic [1:0] irq_msk;
  logic [7:0] next_control;
  logic [7:0] next_status;
  logic [7:0] next_ien2;
  logic [1:0] next_irq_st;
  logic [1:0] next_irq_msk;
  logic [7:0] next_rdata;
  logic       detect;
  logic       detect_d;
  logic       next_detect_d;
  logic       wake_now;

  // ****************************************
  // Register index
  // ****************************************
  localparam int REG_COUNT   = 5;
  localparam int IDX_CONTROL = 0;
  localparam int IDX_STATUS  = 1;
  localparam int IDX_IEN2    = 2;
  localparam int IDX_IRQ_ST  = 3;
  localparam int IDX_IRQ_MSK = 4;

  logic [REG_COUNT-1:0] wr_sel;
  logic [REG_COUNT-1:0] rd_sel;
  logic [7:0]           reg_view [REG_COUNT];

  function automatic logic [7:0] addr_of(input int idx);
    case (idx)
      IDX_CONTROL: addr_of = KPLW_ADDR_CONTROL;
      IDX_STATUS:  addr_of = KPLW_ADDR_STATUS;
      IDX_IEN2:    addr_of = KPLW_ADDR_IEN2;
      IDX_IRQ_ST:  addr_of = KPLW_ADDR_IRQ_ST;
      IDX_IRQ_MSK: addr_of = KPLW_ADDR_IRQ_MSK;
      default:     addr_of = 8'hFF;
    endcase
  endfunction

  function automatic logic hit(input kplw_bus_t b, input logic [7:0] a);
    hit = (b.addr == a);
  endfunction

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign cfg = '{key_level_select: control[KPLW_CTL_LEVEL_BIT],
                 key_irq_mask:     control[KPLW_CTL_MASK_BIT],
                 key_wake_enable:  status[KPLW_STA_WAKE_BIT],
                 key_irq_enable:   ien2[KPLW_IEN_KEY_BIT]};

  assign detect   = (key_sync == cfg.key_level_select);
  assign wake_now = detect & cfg.key_wake_enable;

  // ****************************************
  // Address decode
  // ****************************************
  for (genvar gi = 0; gi < REG_COUNT; gi++) begin : g_sel
    assign wr_sel[gi] = bus.wr & hit(bus, addr_of(gi));
    assign rd_sel[gi] = bus.rd & hit(bus, addr_of(gi));
  end

  // ****************************************
  // Control register
  // ****************************************
  always_comb begin
    next_control = control;
    if (wr_sel[IDX_CONTROL]) begin
      next_control = {6'h00, bus.wdata[1:0]};
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      control <= KPLW_RST_CONTROL;
    end else begin
      control <= next_control;
    end
  end

  // ****************************************
  // Status register
  // ****************************************
  always_comb begin
    next_status = status;
    if (wr_sel[IDX_STATUS]) begin
      next_status[KPLW_STA_WAKE_BIT] = bus.wdata[KPLW_STA_WAKE_BIT];
    end
    if (rd_sel[IDX_STATUS]) begin
      next_status[KPLW_STA_FLAG_BIT] = 1'b0;
    end
    // Set wins over read clear
    if (detect) begin
      next_status[KPLW_STA_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      status <= KPLW_RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // ****************************************
  // Interrupt enable register
  // ****************************************
  always_comb begin
    next_ien2 = ien2;
    if (wr_sel[IDX_IEN2]) begin
      next_ien2 = {7'h00, bus.wdata[KPLW_IEN_KEY_BIT]};
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ien2 <= KPLW_RST_IEN2;
    end else begin
      ien2 <= next_ien2;
    end
  end

  // ****************************************
  // Event mask register
  // ****************************************
  always_comb begin
    next_irq_msk = irq_msk;
    if (wr_sel[IDX_IRQ_MSK]) begin
      next_irq_msk = bus.wdata[1:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_msk <= KPLW_RST_EVT;
    end else begin
      irq_msk <= next_irq_msk;
    end
  end

  // ****************************************
  // Event status register
  // ****************************************
  always_comb begin
    next_irq_st = irq_st;
    if (wr_sel[IDX_IRQ_ST]) begin
      next_irq_st = irq_st & ~bus.wdata[1:0];
    end
    // Set wins over write clear
    if (detect && !detect_d) begin
      next_irq_st[KPLW_EVT_DETECT_BIT] = 1'b1;
    end
    if (wake_now) begin
      next_irq_st[KPLW_EVT_WAKE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_st <= KPLW_RST_EVT;
    end else begin
      irq_st <= next_irq_st;
    end
  end

  // ****************************************
  // Detect edge tracker
  // ****************************************
  always_comb begin
    next_detect_d = detect;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      detect_d <= 1'b0;
    end else begin
      detect_d <= next_detect_d;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  assign reg_view[IDX_CONTROL] = control;
  assign reg_view[IDX_STATUS]  = status;
  assign reg_view[IDX_IEN2]    = ien2;
  assign reg_view[IDX_IRQ_ST]  = {6'h00, irq_st};
  assign reg_view[IDX_IRQ_MSK] = {6'h00, irq_msk};

  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (rd_sel[i]) begin
        next_rdata = reg_view[i];
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign KEY_IRQ = status[KPLW_STA_FLAG_BIT] & ~cfg.key_irq_mask &
                   cfg.key_irq_enable;
  // Raw pin path so wake works with clocks stopped
  assign WAKE_REQ = cfg.key_wake_enable &
                    (KEYPAD_INPUT_LINE == cfg.key_level_select);
  assign IRQ = |(irq_st & irq_msk);

endmodule

/* verification/kplw_asserts.sv */
// Port checker of the keypad block
`timescale 1ns/100ps
module kplw_asserts
  import kplw_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       KEYPAD_INPUT_LINE,
  input wire logic       KEY_IRQ,
  input wire logic       WAKE_REQ,
  input wire logic       IRQ
);
  logic sel, msk, en, wk;
  wire  act = KEYPAD_INPUT_LINE == sel;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) {wk, en, msk, sel} <= 4'h0;
    else if (WR && ADDR == KPLW_ADDR_CONTROL) {msk, sel} <= WDATA[1:0];
    else if (WR && ADDR == KPLW_ADDR_STATUS) wk <= WDATA[1];
    else if (WR && ADDR == KPLW_ADDR_IEN2) en <= WDATA[0];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_rd; RD && ADDR == KPLW_ADDR_STATUS; endsequence
  property p_msk; msk |-> !KEY_IRQ; endproperty
  a_msk: assert property (p_msk) else $error("irq while masked");
  property p_en; !en |-> !KEY_IRQ; endproperty
  a_en: assert property (p_en) else $error("irq while disabled");
  property p_wk; !wk |-> !WAKE_REQ; endproperty
  a_wk: assert property (p_wk) else $error("wake while off");
  property p_wkon; wk && act |-> WAKE_REQ; endproperty
  a_wkon: assert property (p_wkon) else $error("no wake");
  property p_irq; (act && en && !msk) [*7] |-> KEY_IRQ; endproperty
  a_irq: assert property (p_irq) else $error("no irq");
  property p_det; act [*7] ##0 s_rd |=> RDATA[0]; endproperty
  a_det: assert property (p_det) else $error("flag not set");
  property p_clr;
    (!act) [*7] ##0 s_rd ##1 (!act && !RD) ##1 !act ##0 s_rd |=> !RDATA[0];
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_rdz; !RD |=> RDATA == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data not idle");
endmodule
bind kplw_top kplw_asserts u_chk (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .KEYPAD_INPUT_LINE, .KEY_IRQ, .WAKE_REQ, .IRQ);

/* verification/kplw_keypad.sv */
// Keypad switch model on the single input line
`timescale 1ns/100ps
module kplw_keypad (
  // Switch
  input  wire logic press,
  input  wire logic act_high,
  // Pin
  output logic      line
);
  assign line = press ? act_high : !act_high;
endmodule

/* verification/tb.sv */
// Testbench of the keypad block
`timescale 1ns/100ps
module tb
  import kplw_pkg::*;
;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0, press = 0, ah = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, q;
  logic       line, kirq, wake, irq;
  int         err_count = 0, checks_done = 0;
  kplw_top u_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .KEYPAD_INPUT_LINE(line), .KEY_IRQ(kirq), .WAKE_REQ(wake), .IRQ(irq));
  kplw_keypad u_key (.press(press), .act_high(ah), .line(line));
  initial forever #12.5 clk = !clk;
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wt;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_level;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) {press, ah} <= {1'b0, s[0]};
      wreg(KPLW_ADDR_CONTROL, {7'h00, s[0]});
      wreg(KPLW_ADDR_IEN2, 8'h01);
      wt;
      rreg(KPLW_ADDR_STATUS);
      rreg(KPLW_ADDR_STATUS);
      chk("flag idle", q, 8'h00);
      @(posedge clk) press <= 1'b1;
      wt;
      chk("irq set", {7'h00, kirq}, 8'h01);
      rreg(KPLW_ADDR_STATUS);
      chk("flag set", q, 8'h01);
      wreg(KPLW_ADDR_CONTROL, {6'h00, 1'b1, s[0]});
      wt;
      chk("irq masked", {7'h00, kirq}, 8'h00);
      wreg(KPLW_ADDR_CONTROL, {7'h00, s[0]});
      wreg(KPLW_ADDR_IEN2, 8'h00);
      wt;
      chk("irq off", {7'h00, kirq}, 8'h00);
    end
    $display("level test done");
  endtask
  task automatic t_wake;
    @(posedge clk) press <= 1'b0;
    wreg(KPLW_ADDR_STATUS, 8'h02);
    @(posedge clk) press <= 1'b1;
    #1 chk("wake", {7'h00, wake}, 8'h01);
    wreg(KPLW_ADDR_IRQ_MSK, 8'h03);
    wt;
    chk("event irq", {7'h00, irq}, 8'h01);
    @(posedge clk) press <= 1'b0;
    wreg(KPLW_ADDR_STATUS, 8'h00);
    wreg(KPLW_ADDR_IRQ_ST, 8'h03);
    wt;
    chk("event clr", {7'h00, irq}, 8'h00);
    @(posedge clk) press <= 1'b1;
    wt;
    chk("no wake", {7'h00, wake}, 8'h00);
    rreg(8'h07);
    chk("unmapped", q, 8'h00);
    $display("wake test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_level;
    t_wake;
    tally_and_finish;
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule
